// >>> logic/spi_eeprom_params.svh
`ifndef SPI_EEPROM_PARAMS_SVH
`define SPI_EEPROM_PARAMS_SVH

`define CLK_PERIOD_NS 5
`define ARRAY_ADDR_W 9
`define PAGE_BYTES 16

`define OP_SET_WRITE_ENABLE 8'h06
`define OP_CLEAR_WRITE_ENABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_MASK 8'hf7
`define OP_READ_MEM 8'h03
`define OP_WRITE_MEM 8'h02
`define OP_ADDR8_BIT 3

`define STATUS_UPPER_ONES 4'hf
`define STATUS_BUSY_BIT 0
`define STATUS_LATCH_BIT 1
`define STATUS_BP_LSB 2
`define STATUS_BP_MSB 3
`define BLOCK_PROTECT_RESET 2'h0

`define INTERNAL_WRITE_TIME_MS 5
`define INTERNAL_WRITE_CYCLES (`INTERNAL_WRITE_TIME_MS * 1000000 / `CLK_PERIOD_NS)
`define POWER_UP_READ_DELAY_US 100
`define POWER_UP_CYCLES ((`POWER_UP_READ_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> logic/spi_eeprom_pkg.sv
`include "spi_eeprom_params.svh"

package spi_eeprom_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_ADDR = 3'h3,
        ST_DATA_IN = 3'h2,
        ST_DATA_OUT = 3'h6,
        ST_IGNORE = 3'h7
    } port_state_e;

    typedef enum logic [2:0] {
        PEND_NONE = 3'h0,
        PEND_SET_WEL = 3'h1,
        PEND_CLR_WEL = 3'h2,
        PEND_WR_MEM = 3'h3,
        PEND_WR_STATUS = 3'h4
    } pend_e;

    typedef struct packed {
        port_state_e state;
        pend_e pend;
        logic [2:0] bit_cnt;
        logic [7:0] shift_in;
        logic target_mem;
        logic [`ARRAY_ADDR_W-1:0] addr;
        logic [7:0] out_shift;
        logic so;
        logic driving;
        logic oe;
        logic write_latch_flag;
        logic [1:0] block_protect;
        logic [7:0] status_data;
        logic busy;
        logic [19:0] busy_cnt;
        logic committing;
        logic [3:0] commit_idx;
        logic [`PAGE_BYTES-1:0] wr_mask;
        logic [14:0] pu_cnt;
        logic pu_done;
    } core_s;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic sck_d;
    } sampler_s;

endpackage

// >>> logic/pin_sync_if.sv
`timescale 1ns/1ps

interface pin_sync_if;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
    logic sck_rise;
    logic sck_fall;

    modport sampler (
        output cs_n,
        output si,
        output hold_n,
        output wp_n,
        output sck_rise,
        output sck_fall
    );

    modport core (
        input cs_n,
        input si,
        input hold_n,
        input wp_n,
        input sck_rise,
        input sck_fall
    );
endinterface

// >>> logic/spi_pin_sampler.sv
`timescale 1ns/1ps

module spi_pin_sampler (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    pin_sync_if.sampler sync
);
    spi_eeprom_pkg::sampler_s st;
    spi_eeprom_pkg::sampler_s next_st;

    // pins idle high so reset fills the stages with ones except the clock
    always_comb begin
        next_st = st;
        next_st.s1 = {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
        next_st.s2 = st.s1;
        next_st.sck_d = st.s2[3];
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= '{s1: 5'h17, s2: 5'h17, sck_d: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign sync.cs_n = st.s2[4];
    assign sync.si = st.s2[2];
    assign sync.hold_n = st.s2[1];
    assign sync.wp_n = st.s2[0];
    // edges only from the second stage, never the first
    assign sync.sck_rise = st.s2[3] & ~st.sck_d;
    assign sync.sck_fall = ~st.s2[3] & st.sck_d;
endmodule

// >>> logic/spi_eeprom_command_port.sv
`timescale 1ns/1ps
`include "spi_eeprom_params.svh"

// What this block does
// - works in clock modes (0,0) and (1,1); host idles clock to match.
// - serial input bits are sampled on each rising clock edge.
// - serial output bit changes on each falling clock edge.
// - chip select high floats output and idles; a running write continues.
// - write-protect low inhibits every write; high permits them.
// - pause low suspends, high resumes without resend; clock low at both.
// - first eight bits after select fall form the instruction byte.
// - set latch 06, clear latch 04, read status 05 are decoded.
// - status write is decoded as opcode 01.
// - memory read is opcode 0000 X011.
// - memory write is opcode 0000 X010.
// - any other opcode byte is ignored with no state change.
// - read is command plus address, then stored data streams out.
// - writes need the write latch set first; rejected while it is clear.
// - self-timed write ends within 5 ms after the closing select rise.
// - opcode bit 3 carries address bit 8 for read and write.
// - status byte: busy, latch, two protect bits, upper nibble ones.
// - during an internal write only read status is accepted.
// - while paused output floats and input edges are ignored.
module spi_eeprom_command_port #(
    parameter logic [19:0] WRITE_CYCLES = 20'(`INTERNAL_WRITE_CYCLES),
    parameter logic [14:0] PU_CYCLES = 15'(`POWER_UP_CYCLES)
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output logic write_busy_o,
    output logic write_latch_flag_o,
    output logic block_protect_low_o,
    output logic block_protect_high_o
);
    localparam int MEM_WORDS = 1 << `ARRAY_ADDR_W;

    pin_sync_if p ();

    spi_pin_sampler sampler (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .cs_n_i(cs_n_i),
        .sck_i(sck_i),
        .si_i(si_i),
        .hold_n_i(hold_n_i),
        .wp_n_i(wp_n_i),
        .sync(p.sampler)
    );

    spi_eeprom_pkg::core_s st;
    spi_eeprom_pkg::core_s next_st;

    logic [7:0] mem [MEM_WORDS];
    logic [7:0] page_buf [`PAGE_BYTES];
    logic [7:0] byte_in;
    logic buf_we;
    logic [3:0] buf_idx;
    logic mem_we;
    logic [`ARRAY_ADDR_W-1:0] mem_idx;

    function automatic logic [7:0] status_byte(input spi_eeprom_pkg::core_s s);
        status_byte = {`STATUS_UPPER_ONES, s.block_protect, s.write_latch_flag, s.busy};
    endfunction

    function automatic logic is_protected(input logic [1:0] bp, input logic [`ARRAY_ADDR_W-1:0] a);
        case (bp)
            2'h1: is_protected = (a[`ARRAY_ADDR_W-1 -: 2] == 2'h3);
            2'h2: is_protected = a[`ARRAY_ADDR_W-1];
            2'h3: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        byte_in = {st.shift_in[6:0], p.si};
        buf_we = 1'b0;
        buf_idx = st.addr[3:0];
        mem_idx = {st.addr[`ARRAY_ADDR_W-1:4], st.commit_idx};
        mem_we = st.busy && st.committing && st.wr_mask[st.commit_idx]
            && !is_protected(st.block_protect, mem_idx);

        if (!st.pu_done) begin
            if (st.pu_cnt == PU_CYCLES - 15'h1) begin
                next_st.pu_done = 1'b1;
            end else begin
                next_st.pu_cnt = st.pu_cnt + 15'h1;
            end
        end

        // the page copy takes sixteen cycles, far inside the write time
        if (st.busy) begin
            if (st.committing) begin
                next_st.committing = (st.commit_idx != 4'hf);
                next_st.commit_idx = st.commit_idx + 4'h1;
            end
            if (st.busy_cnt == WRITE_CYCLES - 20'h1) begin
                next_st.busy = 1'b0;
                next_st.write_latch_flag = 1'b0;
            end else begin
                next_st.busy_cnt = st.busy_cnt + 20'h1;
            end
        end

        if (p.cs_n) begin
            next_st.state = spi_eeprom_pkg::ST_IDLE;
            next_st.oe = 1'b0;
            next_st.driving = 1'b0;
            next_st.bit_cnt = 3'h0;
            next_st.pend = spi_eeprom_pkg::PEND_NONE;
            // the closing select edge commits what the frame asked for
            if (st.state != spi_eeprom_pkg::ST_IDLE) begin
                case (st.pend)
                    spi_eeprom_pkg::PEND_SET_WEL: begin
                        next_st.write_latch_flag = 1'b1;
                    end
                    spi_eeprom_pkg::PEND_CLR_WEL: begin
                        next_st.write_latch_flag = 1'b0;
                    end
                    spi_eeprom_pkg::PEND_WR_MEM: begin
                        if (p.wp_n && st.write_latch_flag && (st.wr_mask != '0)) begin
                            next_st.busy = 1'b1;
                            next_st.busy_cnt = 20'h0;
                            next_st.committing = 1'b1;
                            next_st.commit_idx = 4'h0;
                        end
                    end
                    spi_eeprom_pkg::PEND_WR_STATUS: begin
                        if (p.wp_n && st.write_latch_flag) begin
                            next_st.block_protect = st.status_data[`STATUS_BP_MSB:`STATUS_BP_LSB];
                            next_st.busy = 1'b1;
                            next_st.busy_cnt = 20'h0;
                            next_st.committing = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (!p.hold_n) begin
            next_st.oe = 1'b0;
        end else if (st.state == spi_eeprom_pkg::ST_IDLE) begin
            next_st.state = spi_eeprom_pkg::ST_OPCODE;
        end else begin
            next_st.oe = st.driving;
            // clock polarity at select fall does not matter: a leading fall is dropped
            if (p.sck_rise && st.state != spi_eeprom_pkg::ST_DATA_OUT
                    && st.state != spi_eeprom_pkg::ST_IGNORE) begin
                next_st.shift_in = byte_in;
                next_st.bit_cnt = st.bit_cnt + 3'h1;
                if (st.bit_cnt == 3'h7) begin
                    case (st.state)
                        spi_eeprom_pkg::ST_OPCODE: begin
                            next_st.state = spi_eeprom_pkg::ST_IGNORE;
                            if (!st.pu_done) begin
                                next_st.state = spi_eeprom_pkg::ST_IGNORE;
                            end else if (byte_in == `OP_READ_STATUS) begin
                                next_st.state = spi_eeprom_pkg::ST_DATA_OUT;
                                next_st.target_mem = 1'b0;
                                next_st.out_shift = status_byte(st);
                            end else if (st.busy) begin
                                next_st.state = spi_eeprom_pkg::ST_IGNORE;
                            end else if (byte_in == `OP_SET_WRITE_ENABLE) begin
                                next_st.pend = spi_eeprom_pkg::PEND_SET_WEL;
                            end else if (byte_in == `OP_CLEAR_WRITE_ENABLE) begin
                                next_st.pend = spi_eeprom_pkg::PEND_CLR_WEL;
                            end else if (byte_in == `OP_WRITE_STATUS) begin
                                if (st.write_latch_flag && p.wp_n) begin
                                    next_st.state = spi_eeprom_pkg::ST_DATA_IN;
                                    // on the write side the flag marks the status register, not the array
                                    next_st.target_mem = 1'b1;
                                end
                            end else if ((byte_in & `OP_READ_MASK) == `OP_READ_MEM) begin
                                next_st.state = spi_eeprom_pkg::ST_ADDR;
                                next_st.target_mem = 1'b1;
                                next_st.addr = {byte_in[`OP_ADDR8_BIT], 8'h00};
                            end else if ((byte_in & `OP_READ_MASK) == `OP_WRITE_MEM) begin
                                if (st.write_latch_flag && p.wp_n) begin
                                    next_st.state = spi_eeprom_pkg::ST_ADDR;
                                    next_st.target_mem = 1'b0;
                                    next_st.wr_mask = '0;
                                    next_st.addr = {byte_in[`OP_ADDR8_BIT], 8'h00};
                                end
                            end
                        end
                        spi_eeprom_pkg::ST_ADDR: begin
                            next_st.addr = {st.addr[`ARRAY_ADDR_W-1], byte_in};
                            if (st.target_mem) begin
                                next_st.state = spi_eeprom_pkg::ST_DATA_OUT;
                                next_st.out_shift = mem[{st.addr[`ARRAY_ADDR_W-1], byte_in}];
                            end else begin
                                next_st.state = spi_eeprom_pkg::ST_DATA_IN;
                            end
                        end
                        spi_eeprom_pkg::ST_DATA_IN: begin
                            if (st.target_mem) begin
                                next_st.status_data = byte_in;
                                next_st.pend = spi_eeprom_pkg::PEND_WR_STATUS;
                                next_st.state = spi_eeprom_pkg::ST_IGNORE;
                            end else begin
                                // page buffer wraps inside the page
                                buf_we = 1'b1;
                                next_st.wr_mask[st.addr[3:0]] = 1'b1;
                                next_st.addr[3:0] = st.addr[3:0] + 4'h1;
                                next_st.pend = spi_eeprom_pkg::PEND_WR_MEM;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (p.sck_fall && st.state == spi_eeprom_pkg::ST_DATA_OUT) begin
                next_st.so = st.out_shift[7];
                next_st.driving = 1'b1;
                next_st.oe = 1'b1;
                next_st.out_shift = {st.out_shift[6:0], 1'b0};
                next_st.bit_cnt = st.bit_cnt + 3'h1;
                if (st.bit_cnt == 3'h7) begin
                    if (st.target_mem) begin
                        next_st.addr = st.addr + 9'h1;
                        next_st.out_shift = mem[st.addr + 9'h1];
                    end else begin
                        next_st.out_shift = status_byte(st);
                    end
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (buf_we) begin
            page_buf[buf_idx] <= byte_in;
        end
        if (mem_we) begin
            mem[mem_idx] <= page_buf[st.commit_idx];
        end
    end

    assign so_o = st.so;
    assign so_oe_o = st.oe;
    assign write_busy_o = st.busy;
    assign write_latch_flag_o = st.write_latch_flag;
    assign block_protect_low_o = st.block_protect[0];
    assign block_protect_high_o = st.block_protect[1];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    cs_float_a: assert property (p.cs_n |=> !so_oe_o)
        else $error("output driven while deselected");
    hold_float_a: assert property (!p.hold_n |=> !so_oe_o)
        else $error("output driven while paused");
    so_on_fall_a: assert property (!$stable(so_o) |-> $past(p.sck_fall))
        else $error("output bit changed off a falling edge");
    sample_on_rise_a: assert property (!$stable(st.shift_in) |-> $past(p.sck_rise))
        else $error("input shifted off a rising edge");
    wp_gate_a: assert property ($rose(st.busy) |-> $past(p.wp_n))
        else $error("write started with protect low");
    latch_gate_a: assert property ($rose(st.busy) |-> $past(st.write_latch_flag))
        else $error("write started without latch");
    write_time_a: assert property ($fell(st.busy) |->
        ($past(st.busy_cnt) == WRITE_CYCLES - 20'h1) && !st.write_latch_flag)
        else $error("write cycle length wrong");
    busy_ignore_a: assert property ((st.busy && st.state == spi_eeprom_pkg::ST_OPCODE && p.sck_rise
        && st.bit_cnt == 3'h7 && !p.cs_n && p.hold_n && byte_in != `OP_READ_STATUS)
        |=> st.state == spi_eeprom_pkg::ST_IGNORE && st.pend == spi_eeprom_pkg::PEND_NONE)
        else $error("command taken during write");
    bad_opcode_a: assert property ((st.state == spi_eeprom_pkg::ST_OPCODE && p.sck_rise
        && st.bit_cnt == 3'h7 && !p.cs_n && p.hold_n && st.shift_in[6:3] != 4'h0)
        |=> st.state == spi_eeprom_pkg::ST_IGNORE && st.pend == spi_eeprom_pkg::PEND_NONE)
        else $error("undefined opcode acted on");
    partial_a: assert property ((p.cs_n && st.state == spi_eeprom_pkg::ST_OPCODE)
        |=> !$rose(st.busy) && !$rose(st.write_latch_flag))
        else $error("partial opcode acted on");
    status_load_a: assert property ((st.state == spi_eeprom_pkg::ST_OPCODE && p.sck_rise && st.pu_done
        && st.bit_cnt == 3'h7 && !p.cs_n && p.hold_n && byte_in == `OP_READ_STATUS)
        |=> st.out_shift == {4'hf, $past(st.block_protect), $past(st.write_latch_flag), $past(st.busy)})
        else $error("status byte wrong");

    read_seen_c: cover property (st.state == spi_eeprom_pkg::ST_DATA_OUT && st.target_mem && so_oe_o);
    write_seen_c: cover property ($rose(st.busy) && st.committing);
    hold_seen_c: cover property (st.driving && !p.hold_n);
endmodule

// >>> bench/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_n_o
);
    logic mode_hi;

    initial begin
        mode_hi = 1'b0;
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1; // pause idles high; xfer drops it only at hold_at
    end

    // clock idles low for (0,0), high for (1,1); open_frame sets it to that level while select is still high
    task automatic open_frame(input logic hi);
        #1.3;
        mode_hi = hi;
        sck_o = hi;
        #32;
        cs_n_o = 1'b0; // session opens on select falling
        #32;
    endtask

    // msb first; in (1,1) the first clock low is the ignored leading fall
    task automatic xfer(input logic [7:0] tx, input int nbits, input int hold_at, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            sck_o = 1'b0;
            if (i == hold_at) begin
                #20;
                hold_n_o = 1'b0; // clock low at both pause edges, select kept low
                #20;
                si_o = ~si_o;
                sck_o = 1'b1;
                #20;
                sck_o = 1'b0;
                #20;
                hold_n_o = 1'b1; // resume with no resend
            end
            si_o = tx[i];
            #32;
            rx[i] = so_i;
            sck_o = 1'b1;
            #32;
        end
    endtask

    // released data line shows the inverse of its last value, not a held copy
    task automatic close_frame;
        if (!mode_hi) begin
            sck_o = 1'b0;
        end
        #32;
        cs_n_o = 1'b1; // session closes on select rising
        si_o = ~si_o;
        #64;
    endtask
endmodule

// >>> bench/tb_spi_eeprom_command_port.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    n_errors++; $display("Error %s expected %h seen %h", nm, ex, gt); end end

module tb_spi_eeprom_command_port;
    localparam logic [19:0] WC = 20'h258;
    localparam logic [14:0] PU = 15'h10;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic cs_n, sck, si, hold_n, so_o, so_oe_o, busy, latch, bp_lo, bp_hi, so_line;
    logic float_pat = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 23;
    int hold_cnt = 0;
    int cs_cnt = 0;
    int busy_run = 0;
    logic [7:0] rx, d0, d1, op;
    logic [8:0] addr;

    always #2.5 ref_clk_i = ~ref_clk_i;

    spi_eeprom_command_port #(.WRITE_CYCLES(WC), .PU_CYCLES(PU)) dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .write_busy_o(busy),
        .write_latch_flag_o(latch), .block_protect_low_o(bp_lo), .block_protect_high_o(bp_hi)
    );

    spi_host_model host_u (.so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .hold_n_o(hold_n));

    // undriven output line wanders every cycle so a stale bit cannot pass
    assign so_line = so_oe_o ? so_o : float_pat;

    always @(posedge ref_clk_i) begin
        float_pat <= ~float_pat;
        hold_cnt <= hold_n ? 0 : hold_cnt + 1;
        cs_cnt <= cs_n ? cs_cnt + 1 : 0;
        if (busy === 1'b1) busy_run <= busy_run + 1;
        if (hold_cnt == 5) `CHK("so_oe_paused", 1'b0, so_oe_o)
        if (cs_cnt == 5) `CHK("so_oe_deselected", 1'b0, so_oe_o)
    end

    function automatic logic [7:0] status_exp(input logic [1:0] bp, input logic l, input logic b);
        return {4'hf, bp, l, b};
    endfunction

    function automatic logic known_op(input logic [7:0] o);
        return o == 8'h06 || o == 8'h04 || o == 8'h05 || o == 8'h01 || (o & 8'hf7) == 8'h03 || (o & 8'hf7) == 8'h02;
    endfunction

    task automatic final_report;
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmd(input logic [7:0] o, input int nbits);
        host_u.open_frame(1'b0);
        host_u.xfer(o, nbits, -1, rx);
        host_u.close_frame();
    endtask

    task automatic rd_status(input logic hi, input int hold_at, output logic [7:0] s);
        host_u.open_frame(hi);
        host_u.xfer(8'h05, 8, -1, s);
        host_u.xfer(8'h00, 8, hold_at, s);
        host_u.close_frame();
    endtask

    task automatic mem_wr(input logic [8:0] a, input logic [7:0] b0, input logic [7:0] b1);
        host_u.open_frame(1'b0);
        host_u.xfer(8'h02 | {4'h0, a[8], 3'h0}, 8, -1, rx);
        host_u.xfer(a[7:0], 8, -1, rx);
        host_u.xfer(b0, 8, -1, rx);
        host_u.xfer(b1, 8, -1, rx);
        host_u.close_frame();
    endtask

    // read is opcode plus address, then data
    task automatic mem_rd(input logic hi, input logic [8:0] a, output logic [7:0] s);
        host_u.open_frame(hi);
        host_u.xfer(8'h03 | {4'h0, a[8], 3'h0}, 8, -1, s);
        host_u.xfer(a[7:0], 8, -1, s);
        host_u.xfer(8'h00, 8, -1, s);
        host_u.close_frame();
    endtask

    // host allows the full self-timed write before going on
    task automatic wait_idle;
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(posedge ref_clk_i);
        `CHK("write_done", 1'b0, busy)
        if (busy !== 1'b0) final_report();
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        `CHK("reset_outputs", 5'h00, {so_oe_o, busy, latch, bp_hi, bp_lo})
        repeat (PU + 10) @(posedge ref_clk_i); // power-up wait
        cmd(8'h06, 8);
        `CHK("latch_set", 1'b1, latch)
        rd_status(1'b0, -1, rx);
        `CHK("status_byte", status_exp(2'h0, 1'b1, 1'b0), rx)
        repeat (4) begin
            op = 8'($random(seed));
            while (known_op(op)) op = op + 8'h01;
            cmd(op, 8);
        end
        `CHK("unknown_ops", 2'b10, {latch, busy})
        cmd(8'h04, 5);
        `CHK("partial_op", 1'b1, latch)
        cmd(8'h04, 8);
        `CHK("latch_clear", 1'b0, latch)
        addr = 9'($random(seed)) | 9'h00f;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        mem_wr(addr, d0, d1);
        `CHK("write_no_latch", 1'b0, busy)
        cmd(8'h06, 8); // latch set before this write
        busy_run = 0;
        mem_wr(addr, d0, d1);
        `CHK("write_started", 1'b1, busy)
        rd_status(1'b1, 3, rx);
        `CHK("status_busy", status_exp(2'h0, 1'b1, 1'b1), rx)
        cmd(8'h04, 8);
        `CHK("busy_ignores", 1'b1, latch)
        wait_idle();
        `CHK("write_time", 1'b1, busy_run >= WC - 1 && busy_run <= WC + 1)
        `CHK("latch_after_write", 1'b0, latch)
        mem_rd(1'b1, addr, rx);
        `CHK("read_first", d0, rx)
        mem_rd(1'b0, {addr[8:4], 4'h0}, rx);
        `CHK("read_wrapped", d1, rx)
        @(posedge ref_clk_i);
        wp_n_i <= 1'b0;
        cmd(8'h06, 8);
        mem_wr(addr, ~d0, ~d1);
        `CHK("wp_blocks", 1'b0, busy)
        mem_rd(1'b0, addr, rx);
        `CHK("wp_kept", d0, rx)
        @(posedge ref_clk_i);
        wp_n_i <= 1'b1;
        host_u.open_frame(1'b0);
        host_u.xfer(8'h01, 8, -1, rx);
        host_u.xfer(8'h0c, 8, -1, rx);
        host_u.close_frame();
        `CHK("status_write", 1'b1, busy)
        wait_idle();
        `CHK("protect_bits", 2'b11, {bp_hi, bp_lo})
        // full protection: the write cycle runs but the array keeps its bytes
        cmd(8'h06, 8);
        mem_wr(addr, ~d0, ~d1);
        `CHK("protected_write", 1'b1, busy)
        wait_idle();
        mem_rd(1'b0, addr, rx);
        `CHK("protected_kept", d0, rx)
        rd_status(1'b0, -1, rx);
        `CHK("status_after", status_exp(2'h3, 1'b0, 1'b0), rx)
        final_report();
    end
endmodule
